// File: src/casp_bclk_gen.sv
// module: master mode bit clock and frame sync divider with edge pulses
`timescale 1ns/1ps
module casp_bclk_gen #(
	parameter int FRAME_BCLKS = casp_pkg::FRAME_BCLKS
) (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       enable,
	input  wire logic [2:0] div_sel,
	input  wire logic       dsp_mode,
	output logic            bclk_q,
	output logic            frame_q,
	output logic            rise_q,
	output logic            fall_q
);
	localparam int CW = 8;
	logic [5:0]    half_cnt_q;
	logic [5:0]    half_last;
	logic [CW-1:0] bit_cnt_q;
	logic [2:0]    div_eff;

	// half period is 2*2^div hclk cycles so data never moves on the cycle of a rise
	assign div_eff   = (div_sel > casp_pkg::DIV_MAX) ? casp_pkg::DIV_MAX : div_sel;
	assign half_last = 6'(({5'h00, 1'b1} << div_eff) * 2 - 1);

	// divider, bit clock toggle and frame counter, held idle outside master mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			half_cnt_q <= 6'h00;
			bit_cnt_q  <= '0;
			bclk_q     <= 1'b0;
			frame_q    <= 1'b0;
			rise_q     <= 1'b0;
			fall_q     <= 1'b0;
		end else if (!enable) begin
			half_cnt_q <= 6'h00;
			bit_cnt_q  <= '0;
			bclk_q     <= 1'b0;
			frame_q    <= 1'b0;
			rise_q     <= 1'b0;
			fall_q     <= 1'b0;
		end else if (half_cnt_q >= half_last) begin
			half_cnt_q <= 6'h00;
			bclk_q     <= !bclk_q;
			rise_q     <= !bclk_q;
			fall_q     <= bclk_q;
			if (bclk_q) begin
				// frame moves with the falling bit clock edge
				bit_cnt_q <= (bit_cnt_q == CW'(FRAME_BCLKS - 1)) ? '0 : bit_cnt_q + 1'b1;
				if (dsp_mode) begin
					frame_q <= (bit_cnt_q == CW'(FRAME_BCLKS - 1));
				end else begin
					frame_q <= (bit_cnt_q == CW'(FRAME_BCLKS - 1)) || (bit_cnt_q < CW'(FRAME_BCLKS / 2 - 1));
				end
			end
		end else begin
			half_cnt_q <= half_cnt_q + 6'h01;
			rise_q     <= 1'b0;
			fall_q     <= 1'b0;
		end
	end
endmodule : casp_bclk_gen

// File: src/casp_pkg.sv
// package: register map, field layout, reset values and encodings of the codec audio serial port
package casp_pkg;
	// register byte offsets
	localparam logic [7:0] REG_FMT_CTRL = 8'h00;
	localparam logic [7:0] REG_CLK_CTRL = 8'h04;
	localparam logic [7:0] REG_ADC_DATA = 8'h08;
	localparam logic [7:0] REG_DAC_DATA = 8'h0C;
	localparam logic [7:0] REG_STATUS   = 8'h10;
	// field positions
	localparam int FP_BIT     = 7;
	localparam int WL_LSB     = 5;
	localparam int FMT_LSB    = 3;
	localparam int DIV_LSB    = 2;
	localparam int MS_BIT     = 0;
	localparam int ST_NEW_BIT = 0;
	localparam int ST_FRM_BIT = 1;
	// reset values
	localparam logic [1:0] WL_RESET  = 2'h2;
	localparam logic [1:0] FMT_RESET = 2'h2;
	localparam logic [2:0] DIV_RESET = 3'h0;
	// word length encodings
	localparam logic [1:0] WL_16 = 2'h0;
	localparam logic [1:0] WL_20 = 2'h1;
	localparam logic [1:0] WL_24 = 2'h2;
	localparam logic [1:0] WL_32 = 2'h3;
	// format encodings
	localparam logic [1:0] FMT_RJ  = 2'h0;
	localparam logic [1:0] FMT_LJ  = 2'h1;
	localparam logic [1:0] FMT_I2S = 2'h2;
	localparam logic [1:0] FMT_DSP = 2'h3;
	// master mode frame length in bit clocks, and reset value of the measured half frame
	localparam int         FRAME_BCLKS   = 64;
	localparam logic [7:0] HALF_LEN_RESET = 8'h20;
	// largest divider exponent; reserved codes act as the largest
	localparam logic [2:0] DIV_MAX = 3'h5;
endpackage : casp_pkg

// File: src/casp_sync.sv
// module: two flip-flop synchroniser with a third stage for edge detection
`timescale 1ns/1ps
module casp_sync #(
	parameter int W = 3
) (
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q_sync,
	output logic      [W-1:0] q_dly
);
	logic [W-1:0] meta_q;

	// one chain per bit; the first stage feeds only the second
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge hclk or negedge hresetn) begin
			if (!hresetn) begin
				meta_q[i] <= 1'b0;
				q_sync[i] <= 1'b0;
				q_dly[i]  <= 1'b0;
			end else begin
				meta_q[i] <= d[i];
				q_sync[i] <= meta_q[i];
				q_dly[i]  <= q_sync[i];
			end
		end
	end
endmodule : casp_sync

// File: src/casp_top.sv
// module: codec audio serial port with AHB-Lite register slave
// Function
// - four wires: adc out, dac in, frame, bclk
// - master drives bclk and frame, slave inputs
// - every word travels msb first
// - master select high generates both clocks
// - master select low follows external clocks
// - left justified msb on first rise
// - left justified trailing cycles carry nothing
// - right justified lsb on last rise
// - right justified leading cycles are padding
// - i2s msb on second rise
// - i2s gap cycles carry no data
// - dsp msb first or second rise by polarity
// - dsp carries the left word only, no right word
// - dsp cycles after left word ignored
// - format rj/lj/i2s/dsp, resets to i2s
// - right justified caps words at 24 bits
// - master clocks divided from master clock
`timescale 1ns/1ps
module casp_top #(
	parameter int FRAME_BCLKS = casp_pkg::FRAME_BCLKS
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire logic        bclk_in,
	output logic             bclk_out,
	output logic             bclk_oe_n,
	input  wire logic        frame_in,
	output logic             frame_out,
	output logic             frame_oe_n,
	input  wire logic        dac_serial_in,
	output logic             adc_serial_out
);
	// configuration registers
	logic        frame_polarity_sel_q;
	logic [1:0]  word_length_sel_q;
	logic [1:0]  format_sel_q;
	logic [2:0]  bit_clock_divider_q;
	logic        master_select_q;
	logic [31:0] adc_word_q;
	logic [31:0] dac_word_q;
	logic        dac_new_q;
	// bus pipeline
	logic        wr_pend_q;
	logic [7:0]  wr_addr_q;
	logic        acc;
	logic        rd_acc;
	// clock sources
	logic        gen_rise;
	logic        gen_fall;
	logic        gen_bclk;
	logic        gen_frame;
	logic [2:0]  sync_now;
	logic [2:0]  sync_old;
	logic        rise_ev;
	logic        fall_ev;
	logic        frm;
	logic        din;
	// bit engine
	logic [7:0]  pos_q;
	logic [7:0]  pos_n;
	logic [7:0]  half_len_q;
	logic        frm_last_q;
	logic        trans;
	logic        left;
	logic [7:0]  wl;
	logic [7:0]  start;
	logic [7:0]  offs;
	logic        in_word;
	logic [4:0]  idx;
	logic        tx_load;
	logic [31:0] tx_word_q;
	logic [31:0] tx_src;
	logic        rx_act_q;
	logic        rx_last_q;
	logic [31:0] rx_sh_q;

	// word length in bits; right justified never exceeds 24
	function automatic logic [7:0] wl_bits(input logic [1:0] sel, input logic [1:0] fmt);
		logic [7:0] n;
		n = 8'h18;
		case (sel)
			casp_pkg::WL_16: n = 8'h10;
			casp_pkg::WL_20: n = 8'h14;
			casp_pkg::WL_24: n = 8'h18;
			casp_pkg::WL_32: n = (fmt == casp_pkg::FMT_RJ) ? 8'h18 : 8'h20;
			default:         n = 8'h18;
		endcase
		return n;
	endfunction : wl_bits

	// read mux over the register map; unmapped offsets read zero
	function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [31:0] fmt_w, input logic [31:0] clk_w,
			input logic [31:0] adc_w, input logic [31:0] dac_w, input logic [31:0] st_w);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (a == casp_pkg::REG_FMT_CTRL) begin
			r = fmt_w;
		end else if (a == casp_pkg::REG_CLK_CTRL) begin
			r = clk_w;
		end else if (a == casp_pkg::REG_ADC_DATA) begin
			r = adc_w;
		end else if (a == casp_pkg::REG_DAC_DATA) begin
			r = dac_w;
		end else if (a == casp_pkg::REG_STATUS) begin
			r = st_w;
		end
		return r;
	endfunction : rd_mux

	// address phase accepted when selected, ready and nonsequential or sequential
	assign acc    = hsel && hready && htrans[1];
	assign rd_acc = acc && !hwrite && (haddr[31:8] == 24'h00_0000);

	// zero wait slave, always okay; hsize is not checked since only words are used
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// write address capture for the following data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else if (hready) begin
			wr_pend_q <= acc && hwrite && (haddr[31:8] == 24'h00_0000);
			wr_addr_q <= haddr[7:0];
		end
	end

	// read data registered at the address phase so it stands in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_acc) begin
			hrdata <= rd_mux(haddr[7:0],
				{24'h00_0000, frame_polarity_sel_q, word_length_sel_q, format_sel_q, 3'h0},
				{27'h000_0000, bit_clock_divider_q, 1'b0, master_select_q},
				adc_word_q, dac_word_q,
				{30'h0000_0000, frm_last_q, dac_new_q});
		end else if (hready) begin
			hrdata <= 32'h0000_0000;
		end
	end

	// configuration writes in the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frame_polarity_sel_q <= 1'b0;
			word_length_sel_q    <= casp_pkg::WL_RESET;
			format_sel_q         <= casp_pkg::FMT_RESET;
			bit_clock_divider_q  <= casp_pkg::DIV_RESET;
			master_select_q      <= 1'b0;
			adc_word_q           <= 32'h0000_0000;
		end else if (wr_pend_q) begin
			if (wr_addr_q == casp_pkg::REG_FMT_CTRL) begin
				frame_polarity_sel_q <= hwdata[casp_pkg::FP_BIT];
				word_length_sel_q    <= hwdata[casp_pkg::WL_LSB +: 2];
				format_sel_q         <= hwdata[casp_pkg::FMT_LSB +: 2];
			end else if (wr_addr_q == casp_pkg::REG_CLK_CTRL) begin
				bit_clock_divider_q <= hwdata[casp_pkg::DIV_LSB +: 3];
				master_select_q     <= hwdata[casp_pkg::MS_BIT];
			end else if (wr_addr_q == casp_pkg::REG_ADC_DATA) begin
				adc_word_q <= hwdata;
			end
		end
	end

	// master clock generation from hclk
	casp_bclk_gen #(
		.FRAME_BCLKS(FRAME_BCLKS)
	) u_gen (
		.hclk    (hclk),
		.hresetn (hresetn),
		.enable  (master_select_q),
		.div_sel (bit_clock_divider_q),
		.dsp_mode(format_sel_q == casp_pkg::FMT_DSP),
		.bclk_q  (gen_bclk),
		.frame_q (gen_frame),
		.rise_q  (gen_rise),
		.fall_q  (gen_fall)
	);

	// slave inputs share one synchroniser so bclk, frame and data stay aligned
	casp_sync #(
		.W(3)
	) u_sync (
		.hclk   (hclk),
		.hresetn(hresetn),
		.d      ({dac_serial_in, frame_in, bclk_in}),
		.q_sync (sync_now),
		.q_dly  (sync_old)
	);

	// pin drivers; enables are low while this end drives
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			bclk_oe_n  <= 1'b1;
			frame_oe_n <= 1'b1;
		end else begin
			bclk_oe_n  <= !master_select_q;
			frame_oe_n <= !master_select_q;
		end
	end
	assign bclk_out  = gen_bclk;
	assign frame_out = gen_frame;

	// event source: own divider in master mode, synchronised pins in slave mode
	assign rise_ev = master_select_q ? gen_rise : (sync_now[0] && !sync_old[0]);
	assign fall_ev = master_select_q ? gen_fall : (!sync_now[0] && sync_old[0]);
	assign frm     = master_select_q ? gen_frame : sync_now[1];
	assign din     = master_select_q ? dac_serial_in : sync_now[2];

	// position of the coming rise counted from the last frame transition, the last rising one in dsp
	always_comb begin
		trans = (format_sel_q == casp_pkg::FMT_DSP) ? (frm && !frm_last_q) : (frm != frm_last_q);
		pos_n = trans ? 8'h00 : ((pos_q == 8'hFF) ? pos_q : pos_q + 8'h01);
		wl    = wl_bits(word_length_sel_q, format_sel_q);
		left  = 1'b1;
		start = 8'h00;
		case (format_sel_q)
			casp_pkg::FMT_LJ: begin
				start = 8'h00;
				left  = frm ^ frame_polarity_sel_q;
			end
			casp_pkg::FMT_I2S: begin
				start = 8'h01;
				left  = !(frm ^ frame_polarity_sel_q);
			end
			casp_pkg::FMT_RJ: begin
				// lsb lands on the last rise of the previous half's length
				start = (half_len_q >= wl) ? half_len_q - wl : 8'h00;
				left  = frm ^ frame_polarity_sel_q;
			end
			default: begin
				start = frame_polarity_sel_q ? 8'h00 : 8'h01;
				left  = 1'b1;
			end
		endcase
		offs    = pos_n - start;
		// only the left word is active; padding and the dsp right slot carry zero
		in_word = left && (pos_n >= start) && (offs < wl);
		idx     = 5'(wl - 8'h01 - offs);
		tx_load = trans && left;
		tx_src  = tx_load ? adc_word_q : tx_word_q;
	end

	// frame tracking at each falling edge; half length measured for right justified
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pos_q      <= 8'hFF;
			frm_last_q <= 1'b0;
			half_len_q <= casp_pkg::HALF_LEN_RESET;
		end else if (fall_ev) begin
			pos_q      <= pos_n;
			frm_last_q <= frm;
			if (frm != frm_last_q) begin
				half_len_q <= (pos_q == 8'hFF) ? casp_pkg::HALF_LEN_RESET : pos_q + 8'h01;
			end
		end
	end

	// transmit on the falling edge so the host samples a settled bit on the rise
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			adc_serial_out <= 1'b0;
			tx_word_q      <= 32'h0000_0000;
			rx_act_q       <= 1'b0;
			rx_last_q      <= 1'b0;
		end else if (fall_ev) begin
			adc_serial_out <= in_word ? tx_src[idx] : 1'b0;
			tx_word_q      <= tx_src;
			rx_act_q       <= in_word;
			rx_last_q      <= in_word && (idx == 5'h00);
		end
	end

	// receive on the rising edge, msb shifted in first, word right aligned
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_sh_q    <= 32'h0000_0000;
			dac_word_q <= 32'h0000_0000;
		end else if (fall_ev && trans) begin
			rx_sh_q <= 32'h0000_0000;
		end else if (rise_ev && rx_act_q) begin
			rx_sh_q <= {rx_sh_q[30:0], din};
			if (rx_last_q) begin
				dac_word_q <= {rx_sh_q[30:0], din};
			end
		end
	end

	// new word flag: a completed word wins over the clear by reading the data register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dac_new_q <= 1'b0;
		end else if (rise_ev && rx_act_q && rx_last_q) begin
			dac_new_q <= 1'b1;
		end else if (rd_acc && (haddr[7:0] == casp_pkg::REG_DAC_DATA)) begin
			dac_new_q <= 1'b0;
		end
	end
endmodule : casp_top

// File: tb/casp_host.sv
// host model: slave mode clocks, dac bits out, adc bits in
`timescale 1ns/1ps
module casp_host (
	input  wire logic        hclk,
	input  wire logic        en,
	input  wire logic        bclk_in,
	input  wire logic        frame_in,
	input  wire logic        adc_serial_out,
	input  wire logic        left_lvl,
	input  wire logic [5:0]  start,
	input  wire logic [5:0]  wl,
	input  wire logic [31:0] dac_word,
	output logic             host_bclk,
	output logic             host_frame,
	output logic             dac_serial_in,
	output logic      [31:0] adc_got,
	output logic      [7:0]  nwords
);
	logic       b_q, f_q;
	logic [2:0] div_q;
	logic [4:0] cnt_q;
	logic [6:0] pos_q, np;
	initial {host_bclk, host_frame, dac_serial_in, adc_got, nwords, b_q, f_q, div_q, cnt_q, pos_q} = '0;
	// 4 hclk high, 4 low: the fastest the slave synchroniser accepts; still when not in use
	always @(posedge hclk) begin
		div_q <= div_q + 3'h1;
		host_bclk <= en & div_q[2];
		if (en && div_q == 3'h0) cnt_q <= cnt_q + 5'h01;
		if (en && div_q == 3'h0 && &cnt_q) host_frame <= ~host_frame;
	end
	// data moves at falls and is taken at rises
	always @(posedge hclk) begin
		b_q <= bclk_in;
		if (b_q && !bclk_in) begin
			np = (frame_in != f_q && frame_in == left_lvl) ? 7'h00 : pos_q + 7'h01;
			f_q <= frame_in;
			pos_q <= np;
			// off-word cycles carry the inverted last bit, so the device must ignore them
			dac_serial_in <= (np >= start && np < start + wl) ? dac_word[wl - 6'h01 - 6'(np - start)]
				: ~dac_serial_in;
		end
		if (!b_q && bclk_in && pos_q >= start && pos_q < start + wl) begin
			adc_got <= {adc_got[30:0], adc_serial_out};
			if (pos_q == start + wl - 7'h01) nwords <= nwords + 8'h01;
		end
	end
endmodule : casp_host

// File: tb/casp_props.sv
// checker: bus answer and serial pin timing of the audio serial port
`timescale 1ns/1ps
module casp_props (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        bclk_in,
	input wire logic        bclk_out,
	input wire logic        bclk_oe_n,
	input wire logic        frame_out,
	input wire logic        frame_oe_n,
	input wire logic        adc_serial_out
);
	logic [5:0] still_q;
	logic       last_q;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// hclk count of one master bclk phase; slack covers the first phase after entering master
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			still_q <= 6'h00;
			last_q  <= 1'b0;
		end else begin
			still_q <= (bclk_oe_n || bclk_out != last_q) ? 6'h00 : still_q + 6'h01;
			last_q  <= bclk_out;
		end
	end
	chk_ready_okay: assert property ($past(hresetn) |-> hreadyout && !hresp)
		else $error("bus not ready or not okay");
	chk_rdata_idle: assert property (!$past(hsel && htrans[1] && !hwrite && hready) |-> hrdata == 32'h0000_0000)
		else $error("read data outside data phase");
	chk_oe_pair: assert property (bclk_oe_n == frame_oe_n)
		else $error("clock enables differ");
	chk_slave_quiet: assert property (bclk_oe_n |-> !bclk_out && !frame_out)
		else $error("clock driven in slave mode");
	chk_frame_fall: assert property (!bclk_oe_n && $past(!bclk_oe_n) && $changed(frame_out) |-> $fell(bclk_out))
		else $error("frame moved off a bclk fall");
	chk_adc_master: assert property (!bclk_oe_n && $past(!bclk_oe_n, 2) && $changed(adc_serial_out)
		|-> !$past(bclk_out) && $past(bclk_out, 2))
		else $error("adc bit moved off a bclk fall");
	chk_adc_slave: assert property (bclk_oe_n && $past(bclk_oe_n, 4) && $changed(adc_serial_out)
		|-> !$past(bclk_in, 2))
		else $error("adc bit moved while bclk high");
	chk_bclk_runs: assert property (still_q < 6'h24)
		else $error("master bclk stalled");
	cov_frame: cover property (!bclk_oe_n && $rose(frame_out));
	cov_slave: cover property (bclk_oe_n && $rose(adc_serial_out));
	cov_read: cover property (hsel && htrans[1] && !hwrite && hready);
endmodule : casp_props
bind casp_top casp_props u_props (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
	.hrdata, .bclk_in, .bclk_out, .bclk_oe_n, .frame_out, .frame_oe_n, .adc_serial_out);

// File: tb/tb_top.sv
// testbench: register access and serial framing in master and slave mode
`timescale 1ns/1ps
module tb_top;
	localparam logic [31:0] ADC_VAL = 32'hC35A_96E1;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, host_en, left_lvl;
	logic        bclk_out, bclk_oe_n, frame_out, frame_oe_n, adc_serial_out;
	logic        host_bclk, host_frame, dac_serial_in, bclk_in, frame_in;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [5:0]  start, wl;
	logic [7:0]  nwords;
	logic [31:0] haddr, hwdata, hrdata, dac_word, adc_got;
	int          error_cnt, n_tests;
	// pin level: the device drives it as master, the host otherwise
	assign bclk_in  = bclk_oe_n ? host_bclk : bclk_out;
	assign frame_in = frame_oe_n ? host_frame : frame_out;
	casp_top #(.FRAME_BCLKS(64)) u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .bclk_in, .bclk_out, .bclk_oe_n, .frame_in,
		.frame_out, .frame_oe_n, .dac_serial_in, .adc_serial_out);
	casp_host u_host (.hclk, .en(host_en), .bclk_in, .frame_in, .adc_serial_out, .left_lvl, .start, .wl,
		.dac_word, .host_bclk, .host_frame, .dac_serial_in, .adc_got, .nwords);
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// bounded wait for hready high at a rising edge
	task automatic rdy;
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hreadyout !== 1'b1 && k < 64);
		if (hreadyout !== 1'b1) begin
			error_cnt++;
			report_and_stop;
		end
	endtask : rdy
	// single word transfer: address phase, then data phase
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h00_0000, a};
		rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		rdy;
		rd = hrdata;
	endtask : ahb
	task automatic t_regs;
		logic [31:0] v;
		chk("oe_n", {31'h0000_0000, bclk_oe_n}, 32'h0000_0001);
		ahb(1'b0, 8'h00, 32'h0000_0000, v);
		chk("fmt reset", v, 32'h0000_0050);
		ahb(1'b0, 8'h04, 32'h0000_0000, v);
		chk("clk reset", v, 32'h0000_0000);
		ahb(1'b1, 8'h08, ADC_VAL, v);
		ahb(1'b0, 8'h08, 32'h0000_0000, v);
		chk("adc data", v, ADC_VAL);
		ahb(1'b0, 8'h14, 32'h0000_0000, v);
		chk("unmapped", v, 32'h0000_0000);
		$display("register test done");
	endtask : t_regs
	// one mono word each way in the given format and length, after a settling word
	task automatic t_link(input logic ms, input logic [1:0] fmt, input logic [1:0] wsel, input logic fp);
		logic [31:0] v, m;
		logic [5:0]  w;
		logic [7:0]  w0;
		int          k;
		w = (wsel == 2'h3) ? 6'h20 : 6'h10 + {2'h0, wsel, 2'h0};
		if (fmt == 2'h0 && w == 6'h20) w = 6'h18;
		m = ~(32'hFFFF_FFFF << w);
		ahb(1'b1, 8'h04, 32'h0000_0000, v);
		ahb(1'b1, 8'h00, {24'h00_0000, fp, wsel, fmt, 3'h0}, v);
		ahb(1'b1, 8'h04, {27'h000_0000, 3'h1, 1'b0, ms}, v);
		start <= (fmt == 2'h0) ? 6'h20 - w : (fmt == 2'h1) ? 6'h00 : (fmt == 2'h2) ? 6'h01 : {5'h00, !fp};
		wl <= w;
		left_lvl <= (fmt == 2'h3) | ((fmt != 2'h2) ^ fp);
		host_en <= !ms;
		w0 = nwords;
		k = 0;
		while (nwords != w0 + 8'h02 && k < 5000) begin
			@(posedge hclk);
			k++;
		end
		if (k >= 5000) begin
			error_cnt++;
			report_and_stop;
		end
		chk("adc word", adc_got & m, ADC_VAL & m);
		chk("oe_n", {31'h0000_0000, bclk_oe_n}, {31'h0000_0000, !ms});
		repeat (4) @(posedge hclk);
		ahb(1'b0, 8'h10, 32'h0000_0000, v);
		chk("new flag", v & 32'h0000_0001, 32'h0000_0001);
		ahb(1'b0, 8'h0C, 32'h0000_0000, v);
		chk("dac word", v, dac_word & m);
		ahb(1'b0, 8'h10, 32'h0000_0000, v);
		chk("flag clear", v & 32'h0000_0001, 32'h0000_0000);
		$display("link test done master %0d format %0d", ms, fmt);
	endtask : t_link
	initial begin
		{hresetn, hsel, hwrite, host_en, left_lvl, htrans, haddr, hwdata, start, wl} = '0;
		hsize = 3'h2;
		dac_word = 32'h9ABC_DEF1;
		error_cnt = 0;
		n_tests = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs;
		t_link(1'b1, 2'h1, 2'h0, 1'b0);
		t_link(1'b1, 2'h0, 2'h0, 1'b0);
		t_link(1'b1, 2'h2, 2'h1, 1'b0);
		t_link(1'b1, 2'h3, 2'h2, 1'b0);
		t_link(1'b1, 2'h3, 2'h0, 1'b1);
		t_link(1'b1, 2'h0, 2'h3, 1'b0);
		t_link(1'b1, 2'h1, 2'h3, 1'b0);
		t_link(1'b0, 2'h1, 2'h2, 1'b0);
		t_link(1'b0, 2'h2, 2'h0, 1'b1);
		t_link(1'b0, 2'h0, 2'h1, 1'b0);
		t_link(1'b0, 2'h3, 2'h0, 1'b0);
		report_and_stop;
	end
endmodule : tb_top
